// *** verilog/rsa_pkg.sv ***
// rsa_pkg: shared types and constants for the rotate/subtract/skip datapath.
// assumes the core decoder encodes each instruction as an rsa_op_e value.
`default_nettype none

package rsa_pkg;

    typedef logic [7:0] rsa_byte_t;

    typedef enum logic [4:0] {
        op_rotate_left_to_acc,
        op_rotate_left_through_carry,
        op_rotate_left_carry_to_acc,
        op_rotate_right,
        op_rotate_right_to_acc,
        op_rotate_right_through_carry,
        op_rotate_right_carry_to_acc,
        op_subtract_with_borrow,
        op_subtract_borrow_to_memory,
        op_minus_memory,
        op_minus_to_memory,
        op_minus_immediate,
        op_decrement_skip_zero,
        op_decrement_skip_zero_to_acc,
        op_increment_skip_zero,
        op_increment_skip_zero_to_acc,
        op_skip_bit_set,
        op_set_byte,
        op_set_bit,
        op_swap_nibbles
    } rsa_op_e;

    typedef enum logic {
        st_exec,
        st_dummy
    } rsa_state_e;

    typedef struct packed {
        rsa_op_e   op;
        rsa_byte_t mem_data;
        rsa_byte_t imm;
        logic [2:0] bit_sel;
    } rsa_instr_s;

    typedef struct packed {
        logic      we;
        rsa_byte_t data;
    } rsa_wb_s;

    // bit 3 sign fault, bit 2 zero, bit 1 nibble carry, bit 0 carry
    typedef struct packed {
        logic result_sign_fault_flag;
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } rsa_flags_s;

    typedef struct packed {
        rsa_flags_s flags;
        rsa_byte_t  res;
    } rsa_alu_s;

    localparam logic [7:0] RSA_OFF_ACC    = 8'h00;
    localparam logic [7:0] RSA_OFF_FLAGS  = 8'h04;
    localparam logic [7:0] RSA_OFF_STATUS = 8'h08;

    localparam rsa_byte_t  RSA_ACC_RST   = 8'h00;
    localparam rsa_flags_s RSA_FLAGS_RST = 4'h0;
    localparam rsa_byte_t  RSA_ALL_ONES  = 8'hff;
    localparam rsa_byte_t  RSA_ONE       = 8'h01;
    localparam rsa_byte_t  RSA_ZERO      = 8'h00;
    localparam int unsigned RSA_STATUS_BUSY_BIT = 16;

    localparam logic [1:0] RSA_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] RSA_HSIZE_WORD    = 3'h2;
    localparam logic       RSA_HRESP_OKAY    = 1'h0;

endpackage

`default_nettype wire

// *** verilog/rsa_alu.sv ***
// rsa_alu: execution datapath for rotates, subtracts, set, swap and skips,
// with an AHB-Lite slave holding accumulator, flags and a skip counter.
// assumes the decoder holds instr until instr_ready and supplies the memory
// byte already read; the memory port takes mem_wb one cycle after issue.
`default_nettype none

module rsa_alu #(
    parameter int unsigned SKIP_CNT_W = 16
) (
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire logic               instr_valid,
    input  wire rsa_pkg::rsa_instr_s instr,
    output logic                    instr_ready,
    output rsa_pkg::rsa_wb_s        mem_wb,
    output logic                    fetch_discard,
    output rsa_pkg::rsa_byte_t      acc,
    output rsa_pkg::rsa_flags_s     flags
);

    if (SKIP_CNT_W < 1 || SKIP_CNT_W > 16) begin : g_chk
        $error("SKIP_CNT_W must be 1..16");
    end

    function automatic rsa_pkg::rsa_alu_s sub_calc(input rsa_pkg::rsa_byte_t a,
                                                   input rsa_pkg::rsa_byte_t b,
                                                   input logic cin);
        logic [8:0]        s;
        logic [4:0]        h;
        rsa_pkg::rsa_alu_s r;
        s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        r.res                          = s[7:0];
        r.flags.carry                  = s[8];
        r.flags.nibble_carry_flag      = h[4];
        r.flags.zero                   = (s[7:0] == rsa_pkg::RSA_ZERO);
        r.flags.result_sign_fault_flag = (a[7] == ~b[7]) && (s[7] != a[7]);
        return r;
    endfunction

    function automatic logic alters_flags(input rsa_pkg::rsa_op_e op);
        return op inside {rsa_pkg::op_rotate_left_through_carry,
                          rsa_pkg::op_rotate_left_carry_to_acc,
                          rsa_pkg::op_rotate_right_through_carry,
                          rsa_pkg::op_rotate_right_carry_to_acc,
                          rsa_pkg::op_subtract_with_borrow,
                          rsa_pkg::op_subtract_borrow_to_memory,
                          rsa_pkg::op_minus_memory,
                          rsa_pkg::op_minus_to_memory,
                          rsa_pkg::op_minus_immediate};
    endfunction

    rsa_pkg::rsa_state_e    state_q;
    rsa_pkg::rsa_byte_t     acc_q;
    rsa_pkg::rsa_flags_s    flags_q;
    rsa_pkg::rsa_wb_s       mem_wb_q;
    logic                   fetch_discard_q;
    logic [SKIP_CNT_W-1:0]  skip_cnt_q;
    logic                   dph_wr_q;
    logic [7:0]             dph_addr_q;
    logic [31:0]            hrdata_q;

    rsa_pkg::rsa_byte_t     m;
    rsa_pkg::rsa_byte_t     res;
    rsa_pkg::rsa_alu_s      sub;
    rsa_pkg::rsa_flags_s    flags_n;
    logic                   acc_we;
    logic                   mem_we;
    logic                   skip_take;
    logic                   fire;
    logic                   addr_ok;
    logic                   bus_acc_wr;
    logic                   bus_flg_wr;

    assign instr_ready   = (state_q == rsa_pkg::st_exec);
    assign fire          = instr_valid && instr_ready;
    assign m             = instr.mem_data;
    assign hreadyout     = 1'b1;
    assign hresp         = rsa_pkg::RSA_HRESP_OKAY;
    assign hrdata        = hrdata_q;
    assign mem_wb        = mem_wb_q;
    assign fetch_discard = fetch_discard_q;
    assign acc           = acc_q;
    assign flags         = flags_q;

    always_comb begin
        res       = rsa_pkg::RSA_ZERO;
        sub       = sub_calc(acc_q, m, flags_q.carry);
        flags_n   = flags_q;
        acc_we    = 1'b0;
        mem_we    = 1'b0;
        skip_take = 1'b0;
        unique case (instr.op)
            rsa_pkg::op_rotate_left_to_acc: begin
                res    = {m[6:0], m[7]};
                acc_we = 1'b1;
            end
            rsa_pkg::op_rotate_left_through_carry, rsa_pkg::op_rotate_left_carry_to_acc: begin
                res           = {m[6:0], flags_q.carry};
                flags_n.carry = m[7];
                mem_we        = (instr.op == rsa_pkg::op_rotate_left_through_carry);
                acc_we        = !mem_we;
            end
            rsa_pkg::op_rotate_right: begin
                res    = {m[0], m[7:1]};
                mem_we = 1'b1;
            end
            rsa_pkg::op_rotate_right_to_acc: begin
                res    = {m[0], m[7:1]};
                acc_we = 1'b1;
            end
            rsa_pkg::op_rotate_right_through_carry, rsa_pkg::op_rotate_right_carry_to_acc: begin
                res           = {flags_q.carry, m[7:1]};
                flags_n.carry = m[0];
                mem_we        = (instr.op == rsa_pkg::op_rotate_right_through_carry);
                acc_we        = !mem_we;
            end
            rsa_pkg::op_subtract_with_borrow, rsa_pkg::op_subtract_borrow_to_memory: begin
                res     = sub.res;
                flags_n = sub.flags;
                mem_we  = (instr.op == rsa_pkg::op_subtract_borrow_to_memory);
                acc_we  = !mem_we;
            end
            rsa_pkg::op_minus_memory, rsa_pkg::op_minus_to_memory,
            rsa_pkg::op_minus_immediate: begin
                sub     = sub_calc(acc_q, m, 1'b1);
                if (instr.op == rsa_pkg::op_minus_immediate) begin
                    sub = sub_calc(acc_q, instr.imm, 1'b1);
                end
                res     = sub.res;
                flags_n = sub.flags;
                mem_we  = (instr.op == rsa_pkg::op_minus_to_memory);
                acc_we  = !mem_we;
            end
            rsa_pkg::op_decrement_skip_zero, rsa_pkg::op_decrement_skip_zero_to_acc: begin
                res       = m - rsa_pkg::RSA_ONE;
                mem_we    = (instr.op == rsa_pkg::op_decrement_skip_zero);
                acc_we    = !mem_we;
                skip_take = (res == rsa_pkg::RSA_ZERO);
            end
            rsa_pkg::op_increment_skip_zero, rsa_pkg::op_increment_skip_zero_to_acc: begin
                res       = m + rsa_pkg::RSA_ONE;
                mem_we    = (instr.op == rsa_pkg::op_increment_skip_zero);
                acc_we    = !mem_we;
                skip_take = (res == rsa_pkg::RSA_ZERO);
            end
            rsa_pkg::op_skip_bit_set: begin
                skip_take = m[instr.bit_sel];
            end
            rsa_pkg::op_set_byte: begin
                res    = rsa_pkg::RSA_ALL_ONES;
                mem_we = 1'b1;
            end
            rsa_pkg::op_set_bit: begin
                res    = m | (rsa_pkg::RSA_ONE << instr.bit_sel);
                mem_we = 1'b1;
            end
            rsa_pkg::op_swap_nibbles: begin
                res    = {m[3:0], m[7:4]};
                mem_we = 1'b1;
            end
            default: res = rsa_pkg::RSA_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q         <= rsa_pkg::st_exec;
            fetch_discard_q <= 1'b0;
        end else begin
            fetch_discard_q <= fire && skip_take;
            unique case (state_q)
                rsa_pkg::st_exec: begin
                    if (fire && skip_take) begin
                        state_q <= rsa_pkg::st_dummy;
                    end
                end
                rsa_pkg::st_dummy: begin
                    state_q <= rsa_pkg::st_exec;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            skip_cnt_q <= '0;
        end else if (fire && skip_take) begin
            skip_cnt_q <= skip_cnt_q + SKIP_CNT_W'(1);
        end
    end

    // no write while dummy, fire is low then
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mem_wb_q <= '0;
        end else begin
            mem_wb_q.we   <= fire && mem_we;
            mem_wb_q.data <= (fire && mem_we) ? res : mem_wb_q.data;
        end
    end

    // instruction beats a software write landing in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acc_q <= rsa_pkg::RSA_ACC_RST;
        end else if (fire && acc_we) begin
            acc_q <= res;
        end else if (bus_acc_wr) begin
            acc_q <= hwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags_q <= rsa_pkg::RSA_FLAGS_RST;
        end else if (fire && alters_flags(instr.op)) begin
            flags_q <= flags_n;
        end else if (bus_flg_wr) begin
            flags_q <= hwdata[3:0];
        end
    end

    assign addr_ok    = hsel && hready && htrans[1];
    assign bus_acc_wr = dph_wr_q && (dph_addr_q == rsa_pkg::RSA_OFF_ACC);
    assign bus_flg_wr = dph_wr_q && (dph_addr_q == rsa_pkg::RSA_OFF_FLAGS);

    // zero wait state: read data registered in the address phase
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dph_wr_q   <= 1'b0;
            dph_addr_q <= '0;
            hrdata_q   <= '0;
        end else begin
            dph_wr_q   <= addr_ok && hwrite;
            dph_addr_q <= addr_ok ? haddr[7:0] : dph_addr_q;
            if (addr_ok && !hwrite) begin
                hrdata_q <= '0;
                unique case (haddr[7:0])
                    rsa_pkg::RSA_OFF_ACC:    hrdata_q[7:0] <= acc_q;
                    rsa_pkg::RSA_OFF_FLAGS:  hrdata_q[3:0] <= flags_q;
                    rsa_pkg::RSA_OFF_STATUS: begin
                        hrdata_q[SKIP_CNT_W-1:0] <= skip_cnt_q;
                        hrdata_q[rsa_pkg::RSA_STATUS_BUSY_BIT] <= !instr_ready;
                    end
                    default: hrdata_q <= '0;
                endcase
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_rot_left_acc: assert property (
        fire && instr.op == rsa_pkg::op_rotate_left_to_acc
        |=> acc_q == {$past(m[6:0]), $past(m[7])} && !mem_wb_q.we)
        else $error("left rotate to acc wrong");
    a_rot_left_carry: assert property (
        fire && instr.op == rsa_pkg::op_rotate_left_through_carry
        |=> mem_wb_q.we && mem_wb_q.data == {$past(m[6:0]), $past(flags_q.carry)}
            && flags_q.carry == $past(m[7]))
        else $error("left rotate through carry wrong");
    a_rot_right_carry: assert property (
        fire && instr.op == rsa_pkg::op_rotate_right_through_carry
        |=> mem_wb_q.we && mem_wb_q.data == {$past(flags_q.carry), $past(m[7:1])}
            && flags_q.carry == $past(m[0]))
        else $error("right rotate through carry wrong");
    a_borrow_sub_acc: assert property (
        fire && instr.op == rsa_pkg::op_subtract_with_borrow
        |=> {flags_q.carry, acc_q} == {1'b0, $past(acc_q)} + {1'b0, ~$past(m)}
            + {8'h00, $past(flags_q.carry)})
        else $error("borrow subtract wrong");

    a_sub_acc_value: assert property (
        fire && instr.op == rsa_pkg::op_minus_memory
        |=> acc_q == rsa_pkg::rsa_byte_t'($past(acc_q) - $past(m))
            && flags_q.zero == (acc_q == rsa_pkg::RSA_ZERO))
        else $error("subtract to acc wrong");

    a_skip_taken: assert property (
        fire && skip_take |=> fetch_discard_q && !instr_ready ##1 instr_ready)
        else $error("taken skip not two cycles");

    a_skip_bit_fast: assert property (
        fire && instr.op == rsa_pkg::op_skip_bit_set && !m[instr.bit_sel]
        |=> instr_ready && !fetch_discard_q)
        else $error("untaken bit skip stalled");

    a_dummy_single: assert property (
        state_q == rsa_pkg::st_dummy |=> state_q == rsa_pkg::st_exec)
        else $error("dummy cycle too long");

    a_dummy_quiet: assert property (
        state_q == rsa_pkg::st_dummy && !dph_wr_q
        |=> !mem_wb_q.we && $stable(acc_q) && $stable(flags_q))
        else $error("dummy cycle changed state");

    a_flags_kept: assert property (
        fire && !alters_flags(instr.op) && !bus_flg_wr |=> $stable(flags_q))
        else $error("flags changed by flag-free op");

    a_set_byte_ones: assert property (
        fire && instr.op == rsa_pkg::op_set_byte
        |=> mem_wb_q.we && mem_wb_q.data == rsa_pkg::RSA_ALL_ONES)
        else $error("byte set wrong");

    a_swap_halves: assert property (
        fire && instr.op == rsa_pkg::op_swap_nibbles
        |=> mem_wb_q.data == {$past(m[3:0]), $past(m[7:4])})
        else $error("swap wrong");

    c_skip_taken: cover property (fire && skip_take ##2 fire);
    c_borrow_overflow: cover property (fire && instr.op == rsa_pkg::op_subtract_with_borrow
                                    ##1 flags_q.result_sign_fault_flag);
    c_bus_read: cover property (addr_ok && !hwrite ##1 hrdata_q != '0);

endmodule

`default_nettype wire

// *** tb/rsa_mem_model.sv ***
// rsa_mem_model: one-byte data memory standing behind the datapath.
// assumes the bench preloads it and the datapath writes back over mem_wb.
`default_nettype none

module rsa_mem_model (
    input  wire logic             ref_clk,
    input  wire logic             load,
    input  wire logic [7:0]       load_val,
    input  wire rsa_pkg::rsa_wb_s mem_wb,
    output logic [7:0]            mem_byte
);
    timeunit 1ns;
    timeprecision 1ps;

    // writeback lands one edge after we; a load from the bench wins
    always_ff @(posedge ref_clk) begin
        if (load)
            mem_byte <= load_val;
        else if (mem_wb.we)
            mem_byte <= mem_wb.data;
    end
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// testbench: drives the instruction port and the register bus of rsa_alu.
// assumes rsa_mem_model supplies the addressed byte and takes writebacks.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
    logic load = 1'h0, issue = 1'h0, hready, hreadyout, hresp, instr_ready, fetch_discard;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [7:0] load_val = 8'h00, imm_q = 8'h00, mem_byte, exp_acc;
    logic [2:0] bs_q = 3'h0;
    logic [15:0] nskip = 16'h0;
    rsa_pkg::rsa_op_e op_q = rsa_pkg::op_rotate_left_to_acc;
    rsa_pkg::rsa_instr_s instr;
    rsa_pkg::rsa_wb_s mem_wb;
    rsa_pkg::rsa_byte_t acc;
    rsa_pkg::rsa_flags_s flags, exp_flg;
    int miscompares = 0, compares = 0;
    logic [7:0] mv [4] = '{8'h01, 8'hff, 8'h00, 8'h80};
    logic [7:0] av [4] = '{8'h80, 8'h7f, 8'h00, 8'h10};
    logic [3:0] fv [4] = '{4'h9, 4'h6, 4'hf, 4'h0};

    assign hready = hreadyout;
    assign instr = {op_q, mem_byte, imm_q, bs_q};

    always #10 ref_clk = ~ref_clk;

    rsa_alu #(.SKIP_CNT_W(16)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(rsa_pkg::RSA_HSIZE_WORD),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .instr_valid(issue), .instr(instr), .instr_ready(instr_ready),
        .mem_wb(mem_wb), .fetch_discard(fetch_discard), .acc(acc), .flags(flags));

    rsa_mem_model mem (.ref_clk(ref_clk), .load(load), .load_val(load_val),
        .mem_wb(mem_wb), .mem_byte(mem_byte));

    task automatic end_of_test;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // single word transfer; waits for hready at both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'h1;
        htrans <= rsa_pkg::RSA_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'h1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'h1) @(posedge ref_clk);
        q = hrdata;
        chk("hresp okay", 32'h0, {31'h0, hresp});
    endtask

    // expected effect of one instruction, worked out independently
    function automatic void ref_op(input rsa_pkg::rsa_op_e o, input logic [7:0] a, m, imm,
        input logic [2:0] bs, input rsa_pkg::rsa_flags_s fi, output logic [7:0] ea, em,
        output rsa_pkg::rsa_flags_s ef, output logic we, sk);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        logic ci;
        ea = a; em = m; ef = fi; we = 1'h0; sk = 1'h0; b = ~m; ci = fi.carry;
        case (o)
            rsa_pkg::op_rotate_left_to_acc: ea = {m[6:0], m[7]};
            rsa_pkg::op_rotate_left_through_carry: begin
                em = {m[6:0], ci}; ef.carry = m[7]; we = 1'h1; end
            rsa_pkg::op_rotate_left_carry_to_acc: begin ea = {m[6:0], ci}; ef.carry = m[7]; end
            rsa_pkg::op_rotate_right: begin em = {m[0], m[7:1]}; we = 1'h1; end
            rsa_pkg::op_rotate_right_to_acc: ea = {m[0], m[7:1]};
            rsa_pkg::op_rotate_right_through_carry: begin
                em = {ci, m[7:1]}; ef.carry = m[0]; we = 1'h1; end
            rsa_pkg::op_rotate_right_carry_to_acc: begin ea = {ci, m[7:1]}; ef.carry = m[0]; end
            rsa_pkg::op_decrement_skip_zero: begin
                em = m - 8'h01; we = 1'h1; sk = (em == 8'h00); end
            rsa_pkg::op_decrement_skip_zero_to_acc: begin ea = m - 8'h01; sk = (ea == 8'h00); end
            rsa_pkg::op_increment_skip_zero: begin
                em = m + 8'h01; we = 1'h1; sk = (em == 8'h00); end
            rsa_pkg::op_increment_skip_zero_to_acc: begin ea = m + 8'h01; sk = (ea == 8'h00); end
            rsa_pkg::op_skip_bit_set: sk = m[bs];
            rsa_pkg::op_set_byte: begin em = 8'hff; we = 1'h1; end
            rsa_pkg::op_set_bit: begin em = m | (8'h01 << bs); we = 1'h1; end
            rsa_pkg::op_swap_nibbles: begin em = {m[3:0], m[7:4]}; we = 1'h1; end
            default: begin
                if (o == rsa_pkg::op_minus_immediate) b = ~imm;
                if (o != rsa_pkg::op_subtract_with_borrow &&
                    o != rsa_pkg::op_subtract_borrow_to_memory) ci = 1'h1;
                s = {1'h0, a} + {1'h0, b} + {8'h00, ci};
                h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, ci};
                ef = {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8]};
                if (o == rsa_pkg::op_subtract_borrow_to_memory ||
                    o == rsa_pkg::op_minus_to_memory) begin em = s[7:0]; we = 1'h1; end
                else ea = s[7:0];
            end
        endcase
    endfunction

    task automatic exec(input rsa_pkg::rsa_op_e o, input logic [7:0] m, input logic [2:0] bs);
        logic [7:0] ea, em;
        rsa_pkg::rsa_flags_s ef;
        logic we, sk;
        int n;
        ref_op(o, exp_acc, m, m ^ 8'h5a, bs, exp_flg, ea, em, ef, we, sk);
        n = 0;
        @(posedge ref_clk);
        load <= 1'h1;
        load_val <= m;
        @(posedge ref_clk);
        load <= 1'h0;
        op_q <= o;
        imm_q <= m ^ 8'h5a;
        bs_q <= bs;
        issue <= 1'h1;
        @(negedge ref_clk);
        while (instr_ready !== 1'h1 && n < 4) begin @(negedge ref_clk); n++; end
        @(posedge ref_clk);
        issue <= 1'h0;
        #1;
        chk($sformatf("acc op %0d", o), ea, acc);
        chk($sformatf("flags op %0d", o), ef, flags);
        chk($sformatf("mem we op %0d", o), we, mem_wb.we);
        chk($sformatf("discard op %0d", o), sk, fetch_discard);
        chk($sformatf("ready op %0d", o), !sk, instr_ready);
        @(posedge ref_clk);
        #1;
        chk($sformatf("mem op %0d", o), em, mem_byte);
        chk($sformatf("acc after op %0d", o), ea, acc);
        chk($sformatf("flags after op %0d", o), ef, flags);
        chk($sformatf("we after op %0d", o), 1'h0, mem_wb.we);
        exp_acc = ea;
        exp_flg = ef;
        nskip = nskip + {15'h0, sk};
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'h0;
        ahb(1'h0, rsa_pkg::RSA_OFF_ACC, 32'h0);
        chk("acc reset", 32'h0, q);
        ahb(1'h1, rsa_pkg::RSA_OFF_FLAGS, 32'hfa);
        ahb(1'h0, rsa_pkg::RSA_OFF_FLAGS, 32'h0);
        chk("flags rw", 32'ha, q);
        ahb(1'h1, 8'h0c, 32'h55);
        ahb(1'h0, 8'h0c, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test bus done");
        // every op over boundary operands and both carry values
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 20; i++) begin
                ahb(1'h1, rsa_pkg::RSA_OFF_ACC, {24'h0, av[j]});
                ahb(1'h1, rsa_pkg::RSA_OFF_FLAGS, {28'h0, fv[j]});
                exp_acc = av[j];
                exp_flg = fv[j];
                exec(rsa_pkg::rsa_op_e'(i), mv[j], 3'(i + j));
            end
        end
        $display("test ops done");
        // request held across the dummy cycle is not taken early
        @(posedge ref_clk);
        load <= 1'h1;
        load_val <= 8'h01;
        @(posedge ref_clk);
        load <= 1'h0;
        op_q <= rsa_pkg::op_decrement_skip_zero_to_acc;
        issue <= 1'h1;
        @(posedge ref_clk);
        op_q <= rsa_pkg::op_set_byte;
        @(posedge ref_clk);
        #1;
        chk("we in dummy", 1'h0, mem_wb.we);
        @(posedge ref_clk);
        issue <= 1'h0;
        #1;
        chk("held op data", 8'hff, mem_wb.data);
        nskip = nskip + 16'h1;
        ahb(1'h1, rsa_pkg::RSA_OFF_STATUS, 32'h0);
        ahb(1'h0, rsa_pkg::RSA_OFF_STATUS, 32'h0);
        chk("status", {16'h0, nskip}, q);
        $display("test held done");
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end
endmodule

`default_nettype wire
